/* File: servo_out_defines.svh */
/*
  constants for the servo status and pulse output block: register offsets,
  field positions, reset values, thresholds and timing figures.
  assumes a 25 mhz control clock and a byte-addressed 32-bit apb map.
*/
`ifndef SERVO_OUT_DEFINES_SVH
`define SERVO_OUT_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_FLAG_SEL      8'h00
`define REG_SPEED_WIN     8'h04
`define REG_DIV_NUM       8'h08
`define REG_DIV_DEN       8'h0c
`define REG_PULSE_CFG     8'h10
`define REG_SCALE_ZINT    8'h14
`define REG_STATUS        8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define SEL_ONE_LSB       0
`define SEL_TWO_LSB       8
`define CFG_REV_B_BIT     0
`define CFG_SRC_SCALE_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define SEL_ONE_RST       4'h0
`define SEL_TWO_RST       4'h1
`define SPEED_WIN_RST     16'h0032
`define DIV_NUM_RST       16'h0001
`define DIV_DEN_RST       16'h0001
`define PULSE_CFG_RST     2'h0
`define SCALE_ZINT_RST    16'h0001

// ----------------------------------------
// thresholds
// ----------------------------------------
`define REGEN_WARN_PCT    8'h55
`define OVERLOAD_WARN_PCT 8'h55
`define BATTERY_LOW_MV    13'h0c80
`define SCALE_HOT_DEGC    8'h41

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_KHZ           25000
`define FAN_LOCK_MS       1000
`define PULSE_MAX_KPPS    4000
`define ENC_COUNTS_REV    10000

`endif

/* File: servo_out_pkg.sv */
/*
  types for the servo status and pulse output block.
  assumes the constants header is compiled alongside.
*/
package servo_out_pkg;

  typedef enum logic [3:0] {
    SEL_TORQUE_LIMIT = 4'h0,
    SEL_ZERO_SPEED   = 4'h1,
    SEL_ALARM_ANY    = 4'h2,
    SEL_REGEN        = 4'h3,
    SEL_OVERLOAD     = 4'h4,
    SEL_BATTERY      = 4'h5,
    SEL_FAN_LOCK     = 4'h6,
    SEL_EXT_SCALE    = 4'h7,
    SEL_IN_SPEED     = 4'h8
  } flag_sel_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } apb_req_t;

  typedef struct packed {
    logic               torque_in_limit;
    logic signed [15:0] motor_speed;
    logic signed [15:0] speed_cmd_pre;
    logic [7:0]         regen_load_pct;
    logic [7:0]         overload_pct;
    logic [12:0]        battery_mv;
    logic               fan_stalled;
    logic [7:0]         scale_temp_c;
    logic               scale_signal_low;
    logic               full_closed;
    logic               vel_or_torque;
  } drive_cond_t;

  typedef struct packed {
    logic step;
    logic dir;
    logic index;
  } count_src_t;

endpackage

/* File: quad_pulse_gen.sv */
/*
  fractional divider and paced quadrature generator.
  assumes one input count per i_step pulse on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module quad_pulse_gen #(
  parameter int W   = 16,
  parameter int GAP = 7
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_step,
  input  wire logic         i_dir,
  input  wire logic [W-1:0] i_num,
  input  wire logic [W-1:0] i_den,
  input  wire logic         i_rev_b,
  output logic              o_a,
  output logic              o_b,
  output logic              o_fire,
  output logic              o_a_rise,
  output logic              o_a_fall
);

  logic [W-1:0]      num_eff;
  logic [W:0]        acc_q;
  logic [W:0]        sum;
  logic              ovf;
  logic signed [3:0] pend_q;
  logic signed [4:0] pend_nx;
  logic [1:0]        cnt_q;
  logic [7:0]        gap_q;
  logic              fire;
  logic              up;

  // ----------------------------------------
  // accumulate numerator against denominator
  // ----------------------------------------
  assign num_eff = (i_num > i_den) ? i_den : i_num;
  assign sum     = acc_q + {1'b0, num_eff};
  assign ovf     = i_step && (i_den != '0) && (sum >= {1'b0, i_den});

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      acc_q <= '0;
    else if (i_step && (i_den != '0))
      acc_q <= ovf ? (sum - {1'b0, i_den}) : sum;
  end

  // ----------------------------------------
  // pending edges and rate pacing
  // ----------------------------------------
  assign up   = !pend_q[3];
  assign fire = (pend_q != 4'sh0) && (gap_q == 8'h00);

  always_comb
  begin
    pend_nx = 5'(pend_q);
    if (ovf)
      pend_nx = i_dir ? (pend_nx + 5'sh01) : (pend_nx - 5'sh01);
    if (fire)
      pend_nx = up ? (pend_nx - 5'sh01) : (pend_nx + 5'sh01);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pend_q <= 4'sh0;
    else if (pend_nx > 5'sh07)
      pend_q <= 4'sh7;
    else if (pend_nx < -5'sh07)
      pend_q <= -4'sh7;
    else
      pend_q <= pend_nx[3:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      gap_q <= 8'h00;
    else if (fire)
      gap_q <= 8'(GAP - 1);
    else if (gap_q != 8'h00)
      gap_q <= gap_q - 8'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cnt_q <= 2'h0;
    else if (fire)
      cnt_q <= up ? (cnt_q + 2'h1) : (cnt_q - 2'h1);
  end

  assign o_a      = cnt_q[1];
  assign o_b      = cnt_q[1] ^ cnt_q[0] ^ i_rev_b;
  assign o_fire   = fire;
  assign o_a_rise = fire && (up ? (cnt_q == 2'h1) : (cnt_q == 2'h0));
  assign o_a_fall = fire && (up ? (cnt_q == 2'h3) : (cnt_q == 2'h2));

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_edge_spacing: assert property (
    @(posedge i_clk) disable iff (i_rst) fire |=> !fire [*6])
    else $error("quadrature edges closer than the rate limit");

  chk_ovf_queues: assert property (
    @(posedge i_clk) disable iff (i_rst)
    ovf && i_dir && !fire && (pend_q < 4'sh6) && !pend_q[3]
    |=> pend_q == $past(pend_q) + 4'sh1)
    else $error("divider overflow did not queue an edge");

endmodule

`default_nettype wire

/* File: servo_status_pulse_out.sv */
/*
  servo drive status flag outputs and divided quadrature pulse output,
  with an apb register slave.
  assumes condition inputs and count sources come from logic on i_clk.
*/
// The implementer's own choices: the register addresses and the APB interface to the registers.
// Function
// - selector 0 drives torque in-limit
// - selector 1: speed below window
// - selector 2: any of five alarms
// - selector 3: regenerative load warning level
// - selector 4: load above 85 percent
// - selector 5: battery below 3.2 volts
// - selector 6: fan stalled over 1s
// - selector 7: scale hot or weak, full-closed
// - selector 8: speed matches command, vel/torque
// - emit divided a, b, z outputs
// - numerator and denominator set ratio
// - reversal picks b phase and source
// - scale index spaced by interval setting
// - pulse rate capped at 4 mpps
// - index also on open-collector pin
// - multiple-of-four resolution, encoder source only: z aligned to a
// - otherwise z one count wide
`timescale 1ns/1ns
`default_nettype none
`include "servo_out_defines.svh"

module servo_status_pulse_out #(
  parameter int unsigned ENC_COUNTS   = `ENC_COUNTS_REV,
  parameter int unsigned FAN_LOCK_CYC = `FAN_LOCK_MS * `CLK_KHZ
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire servo_out_pkg::apb_req_t    i_apb,
  output logic [31:0]                     o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  input  wire servo_out_pkg::drive_cond_t i_cond,
  input  wire servo_out_pkg::count_src_t  i_enc,
  input  wire servo_out_pkg::count_src_t  i_scale,
  output logic                            o_torque_limit_flag_out,
  output logic                            o_zero_speed_out,
  output logic                            o_quad_out_phase_a,
  output logic                            o_quad_out_phase_b,
  output logic                            o_index_out_diff,
  input  wire logic                       i_index_out_open_collector,
  output logic                            o_index_out_open_collector,
  output logic                            o_index_out_open_collector_oe
);

  localparam int GAP_CYC = (`CLK_KHZ + `PULSE_MAX_KPPS - 1) / `PULSE_MAX_KPPS;
  localparam int FW      = $clog2(FAN_LOCK_CYC + 1);

  servo_out_pkg::flag_sel_t flag_out_one_select_q;
  servo_out_pkg::flag_sel_t flag_out_two_select_q;
  logic [15:0]              speed_window_setting_q;
  logic [15:0]              pulse_div_numerator_q;
  logic [15:0]              pulse_div_denominator_q;
  logic [1:0]               pulse_logic_reversal_q;
  logic [15:0]              scale_index_interval_q;

  logic          ready_q;
  logic          acc_phase;
  logic          do_wr;
  logic          hit;
  logic [31:0]   rd_data;
  logic [FW-1:0] fan_cnt_q;
  logic          fan_lock;
  logic [16:0]   speed_mag;
  logic [16:0]   slip_mag;
  logic [8:0]    cond_vec;
  logic [8:0]    cond_q;
  logic          aligned_q;
  logic          src_scale;
  logic          step;
  logic          dir;
  logic [15:0]   zcnt_q;
  logic          scale_z_evt;
  logic          idx_evt;
  logic          aligned;
  logic          z_req_q;
  logic          z_q;
  logic          qa;
  logic          qb;
  logic          a_rise;
  logic          a_fall;
  logic          oc_meta_q;
  logic          oc_sync_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [16:0] mag(input logic signed [16:0] v);
    mag = v[16] ? 17'(-v) : 17'(v);
  endfunction

  function automatic logic pick(input servo_out_pkg::flag_sel_t s, input logic [8:0] c);
    pick = (s <= servo_out_pkg::SEL_IN_SPEED) ? c[s] : 1'b0;
  endfunction

  function automatic logic mult_of_four(input logic [15:0] n, input logic [15:0] d);
    logic [47:0] p;
    logic [17:0] d4;
    p  = 48'(ENC_COUNTS) * 48'(n);
    d4 = {d, 2'h0};
    mult_of_four = (d != 16'h0000) && ((p % 48'(d4)) == 48'h0);
  endfunction

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign acc_phase = i_apb.psel && i_apb.penable;
  assign do_wr     = acc_phase && ready_q && i_apb.pwrite;

  always_comb
  begin
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    case (i_apb.paddr)
      `REG_FLAG_SEL:
        rd_data = {20'h00000, 4'(flag_out_two_select_q), 4'h0, 4'(flag_out_one_select_q)};
      `REG_SPEED_WIN:
        rd_data = {16'h0000, speed_window_setting_q};
      `REG_DIV_NUM:
        rd_data = {16'h0000, pulse_div_numerator_q};
      `REG_DIV_DEN:
        rd_data = {16'h0000, pulse_div_denominator_q};
      `REG_PULSE_CFG:
        rd_data = {30'h00000000, pulse_logic_reversal_q};
      `REG_SCALE_ZINT:
        rd_data = {16'h0000, scale_index_interval_q};
      `REG_STATUS:
        rd_data = {19'h00000, oc_sync_q, aligned_q, cond_q,
                   o_zero_speed_out, o_torque_limit_flag_out};
      default:
        hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ready_q <= 1'b0;
    else
      ready_q <= acc_phase && !ready_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (acc_phase && !ready_q)
    begin
      o_prdata  <= i_apb.pwrite ? 32'h0000_0000 : rd_data;
      o_pslverr <= !hit;
    end
    else
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
  end

  assign o_pready = ready_q;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      flag_out_one_select_q   <= servo_out_pkg::flag_sel_t'(`SEL_ONE_RST);
      flag_out_two_select_q   <= servo_out_pkg::flag_sel_t'(`SEL_TWO_RST);
      speed_window_setting_q  <= `SPEED_WIN_RST;
      pulse_div_numerator_q   <= `DIV_NUM_RST;
      pulse_div_denominator_q <= `DIV_DEN_RST;
      pulse_logic_reversal_q  <= `PULSE_CFG_RST;
      scale_index_interval_q  <= `SCALE_ZINT_RST;
    end
    else if (do_wr)
    begin
      case (i_apb.paddr)
        `REG_FLAG_SEL:
        begin
          flag_out_one_select_q <= servo_out_pkg::flag_sel_t'(i_apb.pwdata[`SEL_ONE_LSB +: 4]);
          flag_out_two_select_q <= servo_out_pkg::flag_sel_t'(i_apb.pwdata[`SEL_TWO_LSB +: 4]);
        end
        `REG_SPEED_WIN:
          speed_window_setting_q <= i_apb.pwdata[15:0];
        `REG_DIV_NUM:
          pulse_div_numerator_q <= i_apb.pwdata[15:0];
        `REG_DIV_DEN:
          pulse_div_denominator_q <= i_apb.pwdata[15:0];
        `REG_PULSE_CFG:
          pulse_logic_reversal_q <= i_apb.pwdata[1:0];
        `REG_SCALE_ZINT:
          scale_index_interval_q <= i_apb.pwdata[15:0];
        default:
          ;
      endcase
    end
  end

  // ----------------------------------------
  // status conditions
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_cond.fan_stalled)
      fan_cnt_q <= '0;
    else if (fan_cnt_q != FW'(FAN_LOCK_CYC))
      fan_cnt_q <= fan_cnt_q + FW'(1);
  end

  assign fan_lock  = (fan_cnt_q == FW'(FAN_LOCK_CYC));
  assign speed_mag = mag(17'(i_cond.motor_speed));
  assign slip_mag  = mag(17'(i_cond.motor_speed) - 17'(i_cond.speed_cmd_pre));

  always_comb
  begin
    cond_vec    = 9'h000;
    cond_vec[0] = i_cond.torque_in_limit;
    cond_vec[1] = speed_mag < {1'b0, speed_window_setting_q};
    cond_vec[3] = i_cond.regen_load_pct >= `REGEN_WARN_PCT;
    cond_vec[4] = i_cond.overload_pct > `OVERLOAD_WARN_PCT;
    cond_vec[5] = i_cond.battery_mv < `BATTERY_LOW_MV;
    cond_vec[6] = fan_lock;
    cond_vec[7] = i_cond.full_closed &&
                  ((i_cond.scale_temp_c > `SCALE_HOT_DEGC) || i_cond.scale_signal_low);
    cond_vec[8] = i_cond.vel_or_torque && (slip_mag <= {1'b0, speed_window_setting_q});
    cond_vec[2] = |cond_vec[7:3];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_torque_limit_flag_out <= 1'b0;
      o_zero_speed_out        <= 1'b0;
      cond_q                  <= 9'h000;
    end
    else
    begin
      o_torque_limit_flag_out <= pick(flag_out_one_select_q, cond_vec);
      o_zero_speed_out        <= pick(flag_out_two_select_q, cond_vec);
      cond_q                  <= cond_vec;
    end
  end

  // ----------------------------------------
  // pulse source and divider
  // ----------------------------------------
  assign src_scale = pulse_logic_reversal_q[`CFG_SRC_SCALE_BIT];
  assign step      = src_scale ? i_scale.step : i_enc.step;
  assign dir       = src_scale ? i_scale.dir : i_enc.dir;

  quad_pulse_gen #(
    .W   (16),
    .GAP (GAP_CYC)
  ) u_quad (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_step   (step),
    .i_dir    (dir),
    .i_num    (pulse_div_numerator_q),
    .i_den    (pulse_div_denominator_q),
    .i_rev_b  (pulse_logic_reversal_q[`CFG_REV_B_BIT]),
    .o_a      (qa),
    .o_b      (qb),
    .o_fire   (),
    .o_a_rise (a_rise),
    .o_a_fall (a_fall)
  );

  // ----------------------------------------
  // index generation
  // ----------------------------------------
  assign scale_z_evt = i_scale.index && ((zcnt_q + 16'h0001) >= scale_index_interval_q);
  assign idx_evt     = src_scale ? scale_z_evt : i_enc.index;
  assign aligned     = !src_scale && aligned_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      zcnt_q <= 16'h0000;
    else if (scale_z_evt)
      zcnt_q <= 16'h0000;
    else if (i_scale.index)
      zcnt_q <= zcnt_q + 16'h0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      aligned_q <= 1'b0;
    else
      aligned_q <= mult_of_four(pulse_div_numerator_q, pulse_div_denominator_q);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      z_req_q <= 1'b0;
    else if (idx_evt && aligned)
      z_req_q <= 1'b1;
    else if (a_rise || !aligned)
      z_req_q <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      z_q <= 1'b0;
    else if (aligned)
    begin
      if (z_req_q && a_rise)
        z_q <= 1'b1;
      else if (a_fall)
        z_q <= 1'b0;
    end
    else if (idx_evt)
      z_q <= 1'b1;
    else if (step)
      z_q <= 1'b0;
  end

  // ----------------------------------------
  // output pins
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_quad_out_phase_a            <= 1'b0;
      o_quad_out_phase_b            <= 1'b0;
      o_index_out_diff              <= 1'b0;
      o_index_out_open_collector    <= 1'b0;
      o_index_out_open_collector_oe <= 1'b0;
    end
    else
    begin
      o_quad_out_phase_a            <= qa;
      o_quad_out_phase_b            <= qb;
      o_index_out_diff              <= z_q;
      o_index_out_open_collector    <= 1'b0;
      o_index_out_open_collector_oe <= z_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      oc_meta_q <= 1'b0;
      oc_sync_q <= 1'b0;
    end
    else
    begin
      oc_meta_q <= i_index_out_open_collector;
      oc_sync_q <= oc_meta_q;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_flag_torque_limit: assert property (
    @(posedge i_clk) disable iff (i_rst)
    flag_out_one_select_q == servo_out_pkg::SEL_TORQUE_LIMIT
    |=> o_torque_limit_flag_out == $past(i_cond.torque_in_limit))
    else $error("torque flag does not follow torque in-limit");

  chk_flag_zero_speed: assert property (
    @(posedge i_clk) disable iff (i_rst)
    flag_out_two_select_q == servo_out_pkg::SEL_ZERO_SPEED
    |=> o_zero_speed_out == ($past(speed_mag) < {1'b0, $past(speed_window_setting_q)}))
    else $error("zero speed flag wrong");

  chk_alarm_any_quiet: assert property (
    @(posedge i_clk) disable iff (i_rst)
    flag_out_one_select_q == servo_out_pkg::SEL_ALARM_ANY && cond_vec[7:3] == 5'h00
    |=> !o_torque_limit_flag_out)
    else $error("alarm flag set with no alarm active");

  chk_overload_level: assert property (
    @(posedge i_clk) disable iff (i_rst)
    flag_out_two_select_q == servo_out_pkg::SEL_OVERLOAD && i_cond.overload_pct > 8'h55
    |=> o_zero_speed_out)
    else $error("overload flag missed");

  chk_battery_low: assert property (
    @(posedge i_clk) disable iff (i_rst)
    flag_out_one_select_q == servo_out_pkg::SEL_BATTERY
    |=> o_torque_limit_flag_out == ($past(i_cond.battery_mv) < 13'h0c80))
    else $error("battery flag wrong");

  chk_fan_clear: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !i_cond.fan_stalled |=> !fan_lock && fan_cnt_q == '0)
    else $error("fan lock held without stall");

  chk_scale_mode: assert property (
    @(posedge i_clk) disable iff (i_rst)
    flag_out_two_select_q == servo_out_pkg::SEL_EXT_SCALE && !i_cond.full_closed
    |=> !o_zero_speed_out)
    else $error("scale flag outside full-closed control");

  chk_in_speed_mode: assert property (
    @(posedge i_clk) disable iff (i_rst)
    flag_out_one_select_q == servo_out_pkg::SEL_IN_SPEED && !i_cond.vel_or_torque
    |=> !o_torque_limit_flag_out)
    else $error("in-speed flag outside velocity or torque control");

  chk_index_narrow: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !aligned && idx_evt |=> ##1 o_index_out_diff)
    else $error("narrow index pulse missing");

  chk_index_mirror: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_index_out_open_collector_oe == o_index_out_diff)
    else $error("open-collector index differs from differential index");

  chk_apb_answer: assert property (
    @(posedge i_clk) disable iff (i_rst)
    acc_phase && !ready_q |=> o_pready ##1 !o_pready)
    else $error("apb answer not one wait state");

endmodule

`default_nettype wire

/* File: host_model.sv */
/* host controller model: decodes quadrature into a position, counts index.
   assumes a, b and the open-collector index level on the bench clock. */
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic i_clk,
  input  wire logic i_a,
  input  wire logic i_b,
  input  wire logic i_z_n,
  output int        o_pos,
  output int        o_nz,
  output int        o_gap,
  output logic      o_seen
);
  logic a_q  = 1'h0;
  logic b_q  = 1'h0;
  logic z_q  = 1'h0;
  int   run  = 100;
  initial
  begin
    o_seen = 1'h0;
    o_pos = 0;
    o_nz = 0;
    o_gap = 100;
  end
  always @(posedge i_clk)
  begin
    a_q <= i_a;
    b_q <= i_b;
    z_q <= !i_z_n;
    run <= run + 1;
    if ((i_a != a_q) || (i_b != b_q))
    begin
      o_pos <= o_pos + ((i_b != a_q) ? 1 : -1);
      o_gap <= (run < o_gap) ? run : o_gap;
      run <= 1;
    end
    if (!i_z_n && !z_q)
    begin
      o_nz <= o_nz + 1;
      o_seen <= 1'h1;
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
/* bench for the status flag and pulse outputs.
   assumes the design package, header and host model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "servo_out_defines.svh"
module tb_top;
  logic                        i_clk = 1'h0;
  logic                        i_rst = 1'h1;
  servo_out_pkg::apb_req_t     req = '0;
  servo_out_pkg::drive_cond_t  cond = '0;
  servo_out_pkg::count_src_t   enc = '0;
  servo_out_pkg::count_src_t   scl = '0;
  logic [31:0]                 prdata, rd;
  logic                        pready, pslverr, er, f1, f2, qa, qb, zd, oc, oe, seen;
  wire logic                   oc_pin = oe ? oc : 1'h1;
  int                          n_fail = 0, n_checks = 0, pos, nz, mg;
  int                          nzd = 0, nal = 0;
  logic                        zd_q = 1'h0, qa_q = 1'h0;
  always #20 i_clk = ~i_clk;
  // counts differential index pulses, and those that rise together with a
  always @(posedge i_clk)
  begin
    zd_q <= zd;
    qa_q <= qa;
    if (zd && !zd_q) nzd <= nzd + 1;
    if (zd && !zd_q && qa && !qa_q) nal <= nal + 1;
  end
  servo_status_pulse_out #(.FAN_LOCK_CYC(20)) servo_status_pulse_out_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_apb(req), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_cond(cond), .i_enc(enc), .i_scale(scl),
    .o_torque_limit_flag_out(f1), .o_zero_speed_out(f2), .o_quad_out_phase_a(qa),
    .o_quad_out_phase_b(qb), .o_index_out_diff(zd), .i_index_out_open_collector(oc_pin),
    .o_index_out_open_collector(oc), .o_index_out_open_collector_oe(oe));
  host_model host_model_i (.i_clk(i_clk), .i_a(qa), .i_b(qb), .i_z_n(oc_pin),
    .o_pos(pos), .o_nz(nz), .o_gap(mg), .o_seen(seen));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'h1, penable: 1'h0};
    @(posedge i_clk);
    req.penable <= 1'h1;
    do
    begin
      @(posedge i_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
    @(posedge i_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    xfer(0, `REG_FLAG_SEL, 0);
    chk(rd, {20'h0, `SEL_TWO_RST, 4'h0, `SEL_ONE_RST}, "sel reset");
    chk(er, 0, "mapped err");
    xfer(0, `REG_SPEED_WIN, 0);
    chk(rd, 32'(`SPEED_WIN_RST), "window reset");
    xfer(0, `REG_DIV_DEN, 0);
    chk(rd, 32'(`DIV_DEN_RST), "den reset");
    xfer(0, 8'h40, 0);
    chk(er, 1, "unmapped err");
    $display("test regs done");
  endtask
  task automatic t_flags;
    for (int s = 0; s < 9; s++)
    begin
      xfer(1, `REG_FLAG_SEL, 32'(s) | (32'(s) << 8));
      cond <= '{1'h1, 16'sh0, 16'sh0, 8'h55, 8'h56, 13'h0c7f, 1'h1, 8'h42, 1'h0, 1'h1, 1'h1};
      repeat (24) @(posedge i_clk);
      chk({f1, f2}, 2'h3, "flag on");
      cond.full_closed <= 1'h0;
      cond.vel_or_torque <= 1'h0;
      repeat (3) @(posedge i_clk);
      chk({f1, f2}, (s == 7 || s == 8) ? 2'h0 : 2'h3, "mode gate");
      cond <= '{1'h0, 16'sh64, 16'sh0, 8'h54, 8'h55, 13'h0c80, 1'h0, 8'h41, 1'h0, 1'h1, 1'h1};
      repeat (3) @(posedge i_clk);
      chk({f1, f2}, 2'h0, "flag off");
    end
    $display("test flags done");
  endtask
  task automatic t_pulse(input logic [15:0] nm, input logic [15:0] dn, input logic [1:0] c,
                         input int ni, input int n, input int g, input logic up,
                         input int exp_d, input int exp_z);
    int p0, z0;
    xfer(1, `REG_DIV_NUM, 32'(nm));
    xfer(1, `REG_DIV_DEN, 32'(dn));
    xfer(1, `REG_PULSE_CFG, 32'(c));
    repeat (5) @(posedge i_clk);
    p0 = pos;
    z0 = nz;
    for (int r = 0; r < ((ni > 0) ? ni : 1); r++)
    begin
      if (ni > 0)
      begin
        {enc, scl} <= c[1] ? {3'h0, 3'h1} : {3'h1, 3'h0};
        @(posedge i_clk);
        {enc, scl} <= '0;
        repeat (9) @(posedge i_clk);
      end
      for (int i = 0; i < n; i++)
      begin
        {enc, scl} <= c[1] ? {3'h0, 1'h1, up, 1'h0} : {1'h1, up, 1'h0, 3'h0};
        @(posedge i_clk);
        if (g > 0)
        begin
          {enc, scl} <= '0;
          repeat (g) @(posedge i_clk);
        end
      end
    end
    {enc, scl} <= '0;
    repeat (60) @(posedge i_clk);
    chk(32'(pos - p0), 32'(exp_d), "position");
    chk(32'(nz - z0), 32'(exp_z), "index count");
    $display("test pulse done");
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge i_clk);
    n_fail++;
    give_verdict;
  end
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'h0;
    repeat (2) @(posedge i_clk);
    t_regs;
    t_flags;
    t_pulse(1, 1, 0, 0, 8, 9, 1, 8, 0);
    t_pulse(1, 2, 0, 0, 8, 9, 1, 4, 0);
    t_pulse(3, 4, 0, 0, 8, 9, 1, 6, 0);
    t_pulse(1, 1, 1, 0, 8, 9, 1, -8, 0);
    t_pulse(1, 1, 0, 0, 8, 9, 0, -8, 0);
    t_pulse(1, 1, 0, 0, 6, 0, 1, 6, 0);
    chk(32'(mg >= 7), 1, "edge spacing");
    xfer(1, `REG_SCALE_ZINT, 2);
    t_pulse(1, 1, 2, 4, 2, 9, 1, 8, 2);
    t_pulse(1, 1, 0, 1, 8, 9, 1, 8, 1);
    t_pulse(1, 3, 0, 1, 8, 9, 1, 2, 1);
    chk(32'(nzd), 32'(4), "diff index count");
    chk(32'(nal), 32'(1), "index aligned to a");
    chk(32'(seen), 32'(1), "index seen");
    give_verdict;
  end
endmodule
`default_nettype wire
